// *** dv/tweec_engine_properties.sv ***
`default_nettype none
module tweec_engine_properties (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic CHIP_SELECT,
  input wire logic SHIFT_CLOCK,
  input wire logic SERIAL_IN,
  input wire logic WORD_WIDTH_STRAP,
  input wire logic SERIAL_OUT,
  input wire logic SERIAL_OUT_OE
);
  // ********
  // Helpers
  // ********
  logic       shift_q_reg, shift_q_next, cs_q_reg, cs_q_next;
  logic [7:0] shift_age_reg, shift_age_next, cs_lo_reg, cs_lo_next;
  always_comb
  begin
    shift_q_next   = SHIFT_CLOCK;
    cs_q_next      = CHIP_SELECT;
    shift_age_next = (SHIFT_CLOCK && !shift_q_reg) ? 8'h00 : shift_age_reg + {7'h00, shift_age_reg != 8'hff};
    cs_lo_next     = CHIP_SELECT ? cs_lo_reg : (cs_q_reg ? 8'h01 : cs_lo_reg + {7'h00, cs_lo_reg != 8'hff});
  end
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      shift_q_reg   <= 1'b0;
      cs_q_reg      <= 1'b0;
      shift_age_reg <= 8'hff;
      cs_lo_reg     <= 8'hff;
    end
    else
    begin
      shift_q_reg   <= shift_q_next;
      cs_q_reg      <= cs_q_next;
      shift_age_reg <= shift_age_next;
      cs_lo_reg     <= cs_lo_next;
    end
  end
  // ********
  // Properties
  // ********
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  sequence quiet_seq;
    !CHIP_SELECT [*6];
  endsequence
  sequence read_start_seq;
    $rose(SERIAL_OUT_OE) ##0 shift_age_reg <= 8'h06;
  endsequence
  AST_FLOAT: assert property (quiet_seq |-> !SERIAL_OUT_OE && !SERIAL_OUT)
    else $error("output driven while deselected");
  AST_CS_OFF: assert property ($fell(CHIP_SELECT) |-> ##[1:5] !SERIAL_OUT_OE)
    else $error("output not released after select fell");
  AST_OUT_STEP: assert property ($changed(SERIAL_OUT) && SERIAL_OUT_OE && $past(SERIAL_OUT_OE)
    |-> shift_age_reg <= 8'h06 || SERIAL_OUT)
    else $error("output changed without shift clock");
  AST_DUMMY: assert property (read_start_seq |-> !SERIAL_OUT)
    else $error("leading bit not zero");
  AST_OE_CS: assert property ($rose(SERIAL_OUT_OE) |-> CHIP_SELECT && $past(CHIP_SELECT, 3))
    else $error("output enabled without select");
  AST_DESEL: assert property ($rose(SERIAL_OUT_OE) && shift_age_reg > 8'h08 |-> cs_lo_reg >= 8'h0d)
    else $error("status after short deselect");
  AST_READY_STAYS: assert property (SERIAL_OUT && SERIAL_OUT_OE && CHIP_SELECT && shift_age_reg > 8'h08
    |=> SERIAL_OUT || !SERIAL_OUT_OE)
    else $error("ready status dropped");
  AST_OE_DROP: assert property ($fell(SERIAL_OUT_OE) |-> !CHIP_SELECT && cs_lo_reg <= 8'h06)
    else $error("output released while selected");
endmodule
bind tweec_engine tweec_engine_properties u_props (.SYS_CLK, .RST_N, .CHIP_SELECT, .SHIFT_CLOCK,
  .SERIAL_IN, .WORD_WIDTH_STRAP, .SERIAL_OUT, .SERIAL_OUT_OE);
`default_nettype wire

// *** dv/tweec_engine_tb_top.sv ***
`default_nettype none
module tweec_engine_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TWP = 600;
  logic        clk, rst_n, strap, out, oe, cs, shift_clock, serial_in, do_w;
  logic        do_last = 1'b0;
  logic [31:0] seed = 32'h9ec56b12;
  logic [15:0] em [512];
  logic [15:0] m;
  logic [63:0] r;
  int          bad_count, tests_run, aw, dw, nw;
  tweec_engine #(.TWP_CYCLES(TWP)) dut (.SYS_CLK(clk), .RST_N(rst_n), .CHIP_SELECT(cs), .SHIFT_CLOCK(shift_clock),
    .SERIAL_IN(serial_in), .WORD_WIDTH_STRAP(strap), .SERIAL_OUT(out), .SERIAL_OUT_OE(oe));
  tweec_host u_host (.clk(clk), .do_w(do_w), .cs(cs), .shift_clock(shift_clock), .serial_in(serial_in));
  // Released line shows the inverse of the last driven level
  assign do_w = oe ? out : ~do_last;
  always @(posedge clk)
    if (oe) do_last <= out;
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [63:0] hdr(input logic [1:0] op, input logic [8:0] a);
    return ((64'h4 | {62'h0, op}) << aw) | ({55'h0, a} & ((64'h1 << aw) - 64'h1));
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("bad_count %0d tests_run %0d", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic run(input logic [1:0] op, input logic [8:0] a, input logic [15:0] d, input logic wd);
    logic [63:0] v;
    v = hdr(op, a);
    if (wd) v = (v << dw) | {48'h0, d};
    u_host.xfer(v, 3 + aw + (wd ? dw : 0), r);
  endtask
  task automatic ext(input logic [1:0] q, input logic [15:0] d);
    run(2'h0, {7'h0, q} << (aw - 2), d, q == 2'h1);
  endtask
  // Reads the word at a and the next one in one frame
  task automatic rd2(input logic [8:0] a);
    logic [63:0] k;
    k = (64'h1 << dw) - 64'h1;
    u_host.xfer(hdr(2'h2, a) << (2 * dw + 1), 4 + aw + 2 * dw, r);
    check({31'h0, r[2 * dw]}, 32'h0);
    check(32'((r >> dw) & k), {16'h0, em[a]});
    check(32'(r & k), {16'h0, em[(int'(a) + 1) % nw]});
  endtask
  task automatic poll(input logic busy);
    int n;
    u_host.select(1'b1);
    if (busy)
    begin
      check({31'h0, do_w}, 32'h0);
      n = 0;
      while (do_w !== 1'b1 && n < 1000)
      begin
        u_host.tk(1);
        n++;
      end
      check({31'h0, do_w}, 32'h1);
    end
    else
      check({31'h0, oe}, 32'h0);
    u_host.select(1'b0);
  endtask
  task automatic phase(input logic w);
    logic [8:0]  a;
    logic [15:0] d;
    strap = w;
    rst_n = 1'b0;
    u_host.tk(8);
    rst_n = 1'b1;
    u_host.tk(4);
    aw = w ? 8 : 9;
    dw = w ? 16 : 8;
    nw = w ? 256 : 512;
    m = w ? 16'hffff : 16'h00ff;
    for (int i = 0; i < 512; i++) em[i] = m;
    seed = lfsr(seed);
    a = seed[8:0] & 9'(nw - 1);
    d = seed[31:16] & m;
    rd2(9'(nw - 1));
    run(2'h1, a, d, 1'b1);
    poll(1'b0);
    rd2(a);
    ext(2'h3, 16'h0);
    run(2'h1, a, d, 1'b1);
    run(2'h1, a, ~d & m, 1'b1);
    poll(1'b1);
    em[a] = d;
    rd2(a);
    run(2'h1, 9'((int'(a) + 1) % nw), ~d & m, 1'b1);
    em[(int'(a) + 1) % nw] = ~d & m;
    u_host.tk(TWP + 50);
    poll(1'b0);
    rd2(a);
    run(2'h3, a, 16'h0, 1'b0);
    poll(1'b1);
    em[a] = m;
    rd2(a);
    seed = lfsr(seed);
    d = seed[15:0] & m;
    ext(2'h1, d);
    poll(1'b1);
    for (int i = 0; i < 512; i++) em[i] = d;
    rd2(seed[24:16] & 9'(nw - 1));
    ext(2'h2, 16'h0);
    poll(1'b1);
    for (int i = 0; i < 512; i++) em[i] = m;
    rd2(a);
    ext(2'h0, 16'h0);
    run(2'h1, a, d, 1'b1);
    poll(1'b0);
    rd2(a);
  endtask
  initial
  begin
    rst_n = 1'b0;
    strap = 1'b0;
    bad_count = 0;
    tests_run = 0;
    phase(1'b0);
    phase(1'b1);
    complete_run();
  end
  initial
  begin
    repeat (60000) @(posedge clk);
    bad_count++;
    complete_run();
  end
endmodule
`default_nettype wire

// *** dv/tweec_host.sv ***
`default_nettype none
module tweec_host (
  input  wire logic clk,
  input  wire logic do_w,
  output logic      cs,
  output logic      shift_clock,
  output logic      serial_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    cs = 1'b0;
    shift_clock = 1'b0;
    serial_in = 1'b0;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic select(input logic v);
    cs = v;
    tk(v ? 6 : 16);
  endtask
  // One frame; each bit is 80 ns low then 80 ns high, all bits clocked
  task automatic xfer(input logic [63:0] v, input int n, output logic [63:0] r);
    logic b;
    r = 64'h0;
    select(1'b1);
    for (int i = n - 1; i >= 0; i--)
    begin
      serial_in = v[i];
      tk(4);
      b = do_w;
      shift_clock = 1'b1;
      tk(4);
      shift_clock = 1'b0;
      r = {r[62:0], b};
    end
    serial_in = ~serial_in;
    select(1'b0);
  endtask
endmodule
`default_nettype wire

// *** hdl/tweec_engine.sv ***
// Behaviour
// - After a read header, the addressed word is shifted out on the output.
// - Read data on the output changes only at shift clock rising edges.
// - A single zero dummy bit precedes the first read word.
// - While select stays high, the read pointer advances and words keep flowing.
// - No dummy bit between consecutive words of a sequential read.
// - Power-up leaves programming disabled; erase and write do nothing.
// - Programming stays enabled until a program disable command.
// - Word erase sets every bit of the word to one.
// - Erase cycle starts right after its address is decoded.
// - Select low for the deselect time then high shows ready/busy.
// - Polled output is low while busy, high once done.
// - Write carries a data word; cycle starts after its last bit.
// - No ready/busy if select rises after the cycle has ended.
// - Erase all sets the whole array to ones, with polling.
// - Fill all writes one data word to every location, with polling.
// - Program disable blocks erase and write; host should send it when done.
// - Reads behave the same whether programming is enabled or not.
// - Address is nine bits for byte words, eight for 16-bit words.
// - Data field is 8 or 16 bits by strap, most significant first.
// - Instruction: select rises, start bit one, two-bit opcode, address.
// - Opcodes read 10, write 01, erase 11; 00 qualified by address top bits.
// - Strap high selects 16-bit words, low selects 8-bit words.
`default_nettype none

module tweec_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [AW:0]      wp_reg, wp_next, rp_reg, rp_next;
  logic [WIDTH-1:0] buf_reg [DEPTH];
  logic [WIDTH-1:0] buf_next [DEPTH];

  always_comb
  begin
    in_ready  = !((wp_reg[AW] != rp_reg[AW]) && (wp_reg[AW-1:0] == rp_reg[AW-1:0]));
    out_valid = (wp_reg != rp_reg);
    out_data  = buf_reg[rp_reg[AW-1:0]];
    buf_next  = buf_reg;
    wp_next   = wp_reg;
    rp_next   = rp_reg;
    if (in_valid && in_ready)
    begin
      buf_next[wp_reg[AW-1:0]] = in_data;
      wp_next = wp_reg + {{AW{1'b0}}, 1'b1};
    end
    if (out_valid && out_ready)
      rp_next = rp_reg + {{AW{1'b0}}, 1'b1};
    if (flush)
    begin
      wp_next = '0;
      rp_next = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      buf_reg <= '{default: '0};
    end
    else
    begin
      wp_reg  <= wp_next;
      rp_reg  <= rp_next;
      buf_reg <= buf_next;
    end
  end
endmodule

module tweec_engine #(
  parameter int TWP_CYCLES  = tweec_pkg::TWP_CYC,
  parameter int BYTE_ADDR_W = tweec_pkg::BYTE_ADDR_W
) (
  input  wire logic SYS_CLK,
  input  wire logic RST_N,
  input  wire logic CHIP_SELECT,
  input  wire logic SHIFT_CLOCK,
  input  wire logic SERIAL_IN,
  input  wire logic WORD_WIDTH_STRAP,
  output logic      SERIAL_OUT,
  output logic      SERIAL_OUT_OE
);
  localparam int MEM_BYTES = 2 ** BYTE_ADDR_W;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [3:0] meta_reg, sync_reg;
  logic       shift_last_reg, cs_last_reg;
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      meta_reg       <= 4'h0;
      sync_reg       <= 4'h0;
      shift_last_reg <= 1'b0;
      cs_last_reg    <= 1'b0;
    end
    else
    begin
      meta_reg       <= {WORD_WIDTH_STRAP, SERIAL_IN, CHIP_SELECT, SHIFT_CLOCK};
      sync_reg       <= meta_reg;
      shift_last_reg <= sync_reg[0];
      cs_last_reg    <= sync_reg[1];
    end
  end

  logic shift_rise, cs_hi, cs_rise, si, wide;
  assign cs_hi      = sync_reg[1];
  assign shift_rise = sync_reg[0] & ~shift_last_reg & cs_hi;
  assign cs_rise    = cs_hi & ~cs_last_reg;
  assign si         = sync_reg[2];
  assign wide       = sync_reg[3];

  function automatic logic [BYTE_ADDR_W-1:0] byte_idx(input logic [8:0] a, input logic w, input logic lo);
    byte_idx = w ? {a[BYTE_ADDR_W-2:0], lo} : a[BYTE_ADDR_W-1:0];
  endfunction

  // ************************************************************
  // Engine state
  // ************************************************************
  tweec_pkg::tweec_state_type state_reg, state_next;
  tweec_pkg::tweec_job_type   job_reg, job_next;
  logic [4:0]  cnt_reg, cnt_next, oleft_reg, oleft_next;
  logic [15:0] sh_reg, sh_next, osh_reg, osh_next;
  logic [1:0]  op_reg, op_next;
  logic [8:0]  addr_reg, addr_next, fptr_reg, fptr_next;
  logic [19:0] busy_cnt_reg, busy_cnt_next;
  logic [3:0]  cslow_reg, cslow_next;
  logic        en_reg, en_next, busy_reg, busy_next, armed_reg, armed_next;
  logic        status_reg, status_next, fetch_reg, fetch_next;
  logic        out_reg, out_next, oe_reg, oe_next;
  logic [7:0]  mem_reg [MEM_BYTES];
  logic [7:0]  mem_next [MEM_BYTES];

  logic [15:0] sh_in, fetch_word, fifo_word;
  logic [1:0]  hop, qual;
  logic [8:0]  haddr;
  logic        flush, push_rdy, fifo_valid, pop, start_job, finish;

  assign sh_in = {sh_reg[14:0], si};
  assign hop   = wide ? sh_in[9:8] : sh_in[10:9];
  assign haddr = wide ? {1'b0, sh_in[7:0]} : sh_in[8:0];
  assign qual  = wide ? sh_in[7:6] : sh_in[8:7];
  assign fetch_word = wide ? {mem_reg[byte_idx(fptr_reg, 1'b1, 1'b0)], mem_reg[byte_idx(fptr_reg, 1'b1, 1'b1)]}
                           : {mem_reg[byte_idx(fptr_reg, 1'b0, 1'b0)], 8'h00};
  assign pop    = shift_rise && (state_reg == tweec_pkg::ST_READ) && (oleft_reg == 5'h00);
  assign finish = busy_reg && (busy_cnt_reg == 20'(TWP_CYCLES - 1));

  tweec_fifo #(
    .WIDTH (tweec_pkg::WORD_W),
    .DEPTH (tweec_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (SYS_CLK),
    .rst_n     (RST_N),
    .flush     (flush),
    .in_valid  (fetch_reg && !flush),
    .in_data   (fetch_word),
    .in_ready  (push_rdy),
    .out_valid (fifo_valid),
    .out_data  (fifo_word),
    .out_ready (pop)
  );

  always_comb
  begin
    state_next = state_reg;
    job_next = job_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    op_next = op_reg;
    addr_next = addr_reg;
    en_next = en_reg;
    fptr_next = fptr_reg;
    fetch_next = fetch_reg;
    osh_next = osh_reg;
    oleft_next = oleft_reg;
    out_next = out_reg;
    oe_next = oe_reg;
    armed_next = armed_reg;
    status_next = status_reg;
    flush = !cs_hi;
    start_job = 1'b0;
    cslow_next = cs_hi ? 4'h0 : (cslow_reg == tweec_pkg::CS_LOW_CYC ? cslow_reg : cslow_reg + 4'h1);
    if (fetch_reg && push_rdy)
      fptr_next = fptr_reg + 9'h001;
    if (shift_rise)
    begin
      case (state_reg)
        tweec_pkg::ST_IDLE:
        begin
          if (si && !busy_reg)
          begin
            state_next = tweec_pkg::ST_HDR;
            cnt_next = 5'h00;
            sh_next = 16'h0000;
            status_next = 1'b0;
            armed_next = 1'b0;
            oe_next = 1'b0;
          end
        end
        tweec_pkg::ST_HDR:
        begin
          sh_next = sh_in;
          cnt_next = cnt_reg + 5'h01;
          addr_next = haddr;
          op_next = hop;
          if (cnt_reg == (wide ? tweec_pkg::HDR_X16_LAST : tweec_pkg::HDR_X8_LAST))
          begin
            cnt_next = 5'h00;
            state_next = tweec_pkg::ST_HOLD;
            job_next = '{all: 1'b0, wide: wide, addr: haddr, data: tweec_pkg::WORD_ERASED};
            case (hop)
              tweec_pkg::OP_READ:
              begin
                state_next = tweec_pkg::ST_READ;
                flush = 1'b1;
                fptr_next = haddr;
                fetch_next = 1'b1;
                out_next = 1'b0;
                oe_next = 1'b1;
                oleft_next = 5'h00;
              end
              tweec_pkg::OP_WRITE:
                state_next = tweec_pkg::ST_DATA;
              tweec_pkg::OP_ERASE:
                start_job = en_reg;
              default:
              begin
                case (qual)
                  tweec_pkg::QUAL_ENABLE:
                    en_next = 1'b1;
                  tweec_pkg::QUAL_DISABLE:
                    en_next = 1'b0;
                  tweec_pkg::QUAL_ERASE_ALL:
                  begin
                    job_next.all = 1'b1;
                    start_job = en_reg;
                  end
                  default:
                    state_next = tweec_pkg::ST_DATA;
                endcase
              end
            endcase
          end
        end
        tweec_pkg::ST_DATA:
        begin
          sh_next = sh_in;
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg == (wide ? tweec_pkg::DATA_X16_LAST : tweec_pkg::DATA_X8_LAST))
          begin
            state_next = tweec_pkg::ST_HOLD;
            job_next = '{all: (op_reg == tweec_pkg::OP_EXT), wide: wide, addr: addr_reg, data: sh_in};
            start_job = en_reg;
          end
        end
        tweec_pkg::ST_READ:
        begin
          if (oleft_reg == 5'h00)
          begin
            out_next = fifo_valid & fifo_word[15];
            osh_next = {fifo_word[14:0], 1'b0};
            oleft_next = wide ? tweec_pkg::DATA_X16_LAST : tweec_pkg::DATA_X8_LAST;
          end
          else
          begin
            out_next = osh_reg[15];
            osh_next = {osh_reg[14:0], 1'b0};
            oleft_next = oleft_reg - 5'h01;
          end
        end
        tweec_pkg::ST_HOLD:
          state_next = tweec_pkg::ST_HOLD;
        default:
          state_next = tweec_pkg::ST_IDLE;
      endcase
    end
    if (start_job)
      armed_next = 1'b1;
    if (!busy_reg && !cs_hi)
      armed_next = 1'b0;
    if (cs_rise && armed_reg && (cslow_reg == tweec_pkg::CS_LOW_CYC))
      status_next = 1'b1;
    if (status_next)
    begin
      out_next = !(busy_reg && !finish);
      oe_next = 1'b1;
    end
    if (!cs_hi)
    begin
      state_next = tweec_pkg::ST_IDLE;
      fetch_next = 1'b0;
      status_next = 1'b0;
      oe_next = 1'b0;
      out_next = 1'b0;
    end
  end

  // ************************************************************
  // Self-timed programming and array
  // ************************************************************
  always_comb
  begin
    busy_next = busy_reg;
    busy_cnt_next = busy_reg ? busy_cnt_reg + 20'h00001 : 20'h00000;
    mem_next = mem_reg;
    if (start_job)
    begin
      busy_next = 1'b1;
      busy_cnt_next = 20'h00000;
    end
    if (finish)
    begin
      busy_next = 1'b0;
      for (int i = 0; i < MEM_BYTES; i++)
      begin
        if (job_reg.all || BYTE_ADDR_W'(i) == byte_idx(job_reg.addr, job_reg.wide, 1'b0))
          mem_next[i] = (job_reg.wide && !i[0]) ? job_reg.data[15:8] : job_reg.data[7:0];
        if (job_reg.wide && !job_reg.all && BYTE_ADDR_W'(i) == byte_idx(job_reg.addr, 1'b1, 1'b1))
          mem_next[i] = job_reg.data[7:0];
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state_reg <= tweec_pkg::ST_IDLE;
      job_reg <= '0;
      cnt_reg <= 5'h00;
      sh_reg <= 16'h0000;
      op_reg <= 2'h0;
      addr_reg <= 9'h000;
      en_reg <= 1'b0;
      fptr_reg <= 9'h000;
      fetch_reg <= 1'b0;
      osh_reg <= 16'h0000;
      oleft_reg <= 5'h00;
      out_reg <= 1'b0;
      oe_reg <= 1'b0;
      armed_reg <= 1'b0;
      status_reg <= 1'b0;
      cslow_reg <= 4'h0;
      busy_reg <= 1'b0;
      busy_cnt_reg <= 20'h00000;
      mem_reg <= '{default: tweec_pkg::BYTE_ERASED};
    end
    else
    begin
      state_reg <= state_next;
      job_reg <= job_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      op_reg <= op_next;
      addr_reg <= addr_next;
      en_reg <= en_next;
      fptr_reg <= fptr_next;
      fetch_reg <= fetch_next;
      osh_reg <= osh_next;
      oleft_reg <= oleft_next;
      out_reg <= out_next;
      oe_reg <= oe_next;
      armed_reg <= armed_next;
      status_reg <= status_next;
      cslow_reg <= cslow_next;
      busy_reg <= busy_next;
      busy_cnt_reg <= busy_cnt_next;
      mem_reg <= mem_next;
    end
  end

  assign SERIAL_OUT    = out_reg;
  assign SERIAL_OUT_OE = oe_reg;
endmodule
`default_nettype wire

// *** hdl/tweec_pkg.sv ***
`default_nettype none
package tweec_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_MHZ   = 50;
  localparam int CS_LOW_NS = 250;
  localparam logic [3:0] CS_LOW_CYC = 4'((CS_LOW_NS * CLK_MHZ + 999) / 1000);
  localparam int TWP_MS    = 10;
  localparam int TWP_CYC   = TWP_MS * CLK_MHZ * 1000;

  // ************************************************************
  // Frame layout
  // ************************************************************
  localparam logic [4:0] HDR_X8_LAST   = 5'h0a;
  localparam logic [4:0] HDR_X16_LAST  = 5'h09;
  localparam logic [4:0] DATA_X8_LAST  = 5'h07;
  localparam logic [4:0] DATA_X16_LAST = 5'h0f;
  localparam int WORD_W     = 16;
  localparam int FIFO_DEPTH = 32;
  localparam int BYTE_ADDR_W = 9;

  // ************************************************************
  // Opcodes and qualifiers
  // ************************************************************
  localparam logic [1:0] OP_EXT   = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ  = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] QUAL_DISABLE   = 2'h0;
  localparam logic [1:0] QUAL_FILL      = 2'h1;
  localparam logic [1:0] QUAL_ERASE_ALL = 2'h2;
  localparam logic [1:0] QUAL_ENABLE    = 2'h3;
  localparam logic [7:0]  BYTE_ERASED = 8'hff;
  localparam logic [15:0] WORD_ERASED = 16'hffff;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_HDR  = 5'h02,
    ST_DATA = 5'h04,
    ST_READ = 5'h08,
    ST_HOLD = 5'h10
  } tweec_state_type;

  typedef struct packed {
    logic        all;
    logic        wide;
    logic [8:0]  addr;
    logic [15:0] data;
  } tweec_job_type;

endpackage
`default_nettype wire
